// file: common/rpc_pkg.sv
// constants and types for one ramped pulse width modulation channel
// assumes one 100 MHz clock shared with the control logic feeding it
`default_nettype none
package rpc_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int RAMP_STEP_MS = 10;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * RAMP_STEP_MS;
  localparam logic signed [31:0] FREQ_MAX = 32'sd40000;
  localparam logic signed [15:0] DUTY_MAX = 16'sd1000;
  // phase accumulator wraps once per output period
  localparam logic [31:0] PHASE_WRAP = 32'(CLK_HZ);
  localparam logic [31:0] DUTY_SCALE = 32'(CLK_HZ / 1000);
  localparam logic [15:0] OUT_SEL_A = 16'h0002;
  localparam logic [15:0] OUT_SEL_B = 16'h0003;
  localparam logic [15:0] OUT_SEL_C = 16'h0004;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] ERR_HARD = 16'h0001;
  localparam logic [15:0] ERR_FREQ = 16'h0003;
  localparam logic [15:0] ERR_DUTY = 16'h0005;
  localparam logic [15:0] ERR_OUTSEL = 16'hFFFF;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACCEL = 2'b01,
    ST_RUN = 2'b10,
    ST_DECEL = 2'b11
  } rpc_state_t;
endpackage
`default_nettype wire

// file: logic/rpc_tick.sv
// 10 ms step tick for the ramp profile
// assumes the parent holds restart high while no ramp is wanted
`default_nettype none
module rpc_tick
  import rpc_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // control
  input wire logic restart,
  output logic tick
);
  logic [31:0] cnt_q, cnt_d;
  logic tick_q, tick_d;

  always_comb begin
    cnt_d = cnt_q + 32'h00000001;
    tick_d = 1'b0;
    if (restart) begin
      cnt_d = 32'h00000000;
    end else if (cnt_q >= 32'(TICKS - 1)) begin
      cnt_d = 32'h00000000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= 32'h00000000;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick = tick_q;
endmodule
`default_nettype wire

// file: logic/rpc_wave.sv
// waveform generator: phase accumulator plus duty compare
// assumes freq and duty already range checked by the parent
`default_nettype none
module rpc_wave
  import rpc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // waveform parameters
  input wire logic run,
  input wire logic [31:0] freq,
  input wire logic [15:0] duty,
  // pin
  output logic wave
);
  logic [31:0] phase_q, phase_d;
  logic wave_q, wave_d;
  logic [32:0] sum;
  logic [31:0] thresh;

  always_comb begin
    sum = {1'b0, phase_q} + {1'b0, freq};
    thresh = 32'(duty * DUTY_SCALE);
    phase_d = (sum >= {1'b0, PHASE_WRAP}) ? 32'(sum - {1'b0, PHASE_WRAP}) : sum[31:0];
    // frequency change keeps phase, so no glitch pulse on retune
    wave_d = run && (freq != 32'h00000000) && (phase_q < thresh);
    if (!run) begin
      phase_d = 32'h00000000;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      phase_q <= 32'h00000000;
      wave_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      wave_q <= wave_d;
    end
  end

  assign wave = wave_q;
endmodule
`default_nettype wire

// file: logic/rpc_channel.sv
// top of one ramped pulse width modulation channel
// assumes setpoints and commands come from logic on the same clock
`default_nettype none
module rpc_channel
  import rpc_pkg::*;
#(
  parameter int TICKS = TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // rung and configuration
  input wire logic enable_in,
  input wire logic [15:0] out_select,
  // control words
  input wire logic hard_stop_cmd,
  input wire logic ramp_target_sel,
  input wire logic [31:0] freq_setpoint,
  input wire logic [15:0] duty_setpoint,
  input wire logic [15:0] ramp_delay,
  // status
  output logic decel_flag,
  output logic run_flag,
  output logic ramp_up_flag,
  output logic idle_flag,
  output logic error_flag,
  output logic normal_flag,
  output logic active_flag,
  output logic sel_state,
  output logic [31:0] freq_actual,
  output logic [15:0] duty_actual,
  output logic [15:0] fault_code,
  // pin
  output logic pwm_out
);

  ////////////////////////////////////////////////////////////////////////
  function automatic logic out_of_range(input logic signed [31:0] v,
                                        input logic signed [31:0] lim);
    out_of_range = (v < 32'sd0) || (v > lim);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  rpc_state_t state_q, state_d;
  logic sel_q, sel_d;
  logic [31:0] freq_q, freq_d;
  logic [15:0] duty_q, duty_d;
  logic [15:0] code_q, code_d;
  logic dec_q, dec_d, run_q, run_d, acc_q, acc_d, idle_q, idle_d;
  logic err_q, err_d, norm_q, norm_d, act_q, act_d;
  logic tick;
  logic wave_run;
  logic [15:0] code_now;
  logic err_now;
  logic [31:0] full;
  logic [31:0] step;
  logic [31:0] ramp_cur;
  logic [31:0] ramp_sp;
  logic [31:0] ramp_up;
  logic [31:0] ramp_dn;
  logic [31:0] ramp_new;
  logic ramp_hit;
  logic ramp_zero;

  ////////////////////////////////////////////////////////////////////////
  // fault decode; configuration fault outranks the rest
  always_comb begin
    if (out_select != OUT_SEL_A && out_select != OUT_SEL_B &&
        out_select != OUT_SEL_C) begin
      code_now = ERR_OUTSEL;
    end else if (hard_stop_cmd) begin
      code_now = ERR_HARD;
    end else if (out_of_range(freq_setpoint, FREQ_MAX)) begin
      code_now = ERR_FREQ;
    end else if (out_of_range({{16{duty_setpoint[15]}}, duty_setpoint},
                              {{16{DUTY_MAX[15]}}, DUTY_MAX})) begin
      code_now = ERR_DUTY;
    end else begin
      code_now = ERR_NONE;
    end
    err_now = (code_now != ERR_NONE);
  end

  ////////////////////////////////////////////////////////////////////////
  // linear step: full scale spread over the ramp delay count
  always_comb begin
    full = sel_q ? 32'(FREQ_MAX) : 32'({16'h0000, DUTY_MAX});
    if (ramp_delay[15] || ramp_delay == 16'h0000) begin
      step = full;
    end else begin
      // divider re-evaluated every cycle so a new delay acts at once
      step = full / {16'h0000, ramp_delay};
    end
    if (step == 32'h00000000) begin
      step = 32'h00000001;
    end
    ramp_cur = sel_q ? freq_q : {16'h0000, duty_q};
    ramp_sp = sel_q ? freq_setpoint : {16'h0000, duty_setpoint};
    ramp_up = ramp_cur + step;
    ramp_dn = (ramp_cur > step) ? ramp_cur - step : 32'h00000000;
    ramp_hit = (ramp_up >= ramp_sp) || (ramp_cur > ramp_sp);
    ramp_zero = (ramp_dn == 32'h00000000);
  end

  ////////////////////////////////////////////////////////////////////////
  // profile sequencer
  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    freq_d = freq_q;
    duty_d = duty_q;
    ramp_new = ramp_cur;
    if (state_q == ST_IDLE) begin
      sel_d = ramp_target_sel;
    end
    case (state_q)
      ST_IDLE: begin
        freq_d = 32'h00000000;
        duty_d = 16'h0000;
        if (enable_in && !err_now) begin
          if (ramp_delay[15] || ramp_delay == 16'h0000) begin
            state_d = ST_RUN;
            freq_d = freq_setpoint;
            duty_d = duty_setpoint;
          end else begin
            state_d = ST_ACCEL;
            freq_d = sel_d ? 32'h00000000 : freq_setpoint;
            duty_d = sel_d ? duty_setpoint : 16'h0000;
          end
        end
      end
      ST_ACCEL: begin
        if (!enable_in) begin
          state_d = ST_DECEL;
        end else if (tick) begin
          if (ramp_hit) begin
            state_d = ST_RUN;
            ramp_new = ramp_sp;
          end else begin
            ramp_new = ramp_up;
          end
        end
      end
      ST_RUN: begin
        if (!enable_in) begin
          state_d = ST_DECEL;
        end else begin
          ramp_new = ramp_sp;
        end
      end
      ST_DECEL: begin
        if (enable_in) begin
          state_d = ST_ACCEL;
        end else if (tick) begin
          ramp_new = ramp_dn;
          if (ramp_zero) begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (state_q != ST_IDLE) begin
      // the parameter not being ramped follows its setpoint directly
      if (sel_q) begin
        freq_d = ramp_new;
        duty_d = duty_setpoint;
      end else begin
        duty_d = ramp_new[15:0];
        freq_d = freq_setpoint;
      end
    end
    if (err_now) begin
      // any fault, hard stop included, drops straight to idle
      state_d = ST_IDLE;
      freq_d = 32'h00000000;
      duty_d = 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // phase flags registered from the next state so they match it; fault flag and code from the decode
  always_comb begin
    dec_d = (state_d == ST_DECEL);
    run_d = (state_d == ST_RUN);
    acc_d = (state_d == ST_ACCEL);
    idle_d = (state_d == ST_IDLE);
    code_d = code_now;
    err_d = err_now;
    norm_d = !err_now && (state_d != ST_IDLE);
    // completion and rung false both clear it
    act_d = enable_in && (state_d != ST_IDLE);
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
      sel_q <= 1'b0;
      freq_q <= 32'h00000000;
      duty_q <= 16'h0000;
      code_q <= ERR_NONE;
      dec_q <= 1'b0;
      run_q <= 1'b0;
      acc_q <= 1'b0;
      idle_q <= 1'b1;
      err_q <= 1'b0;
      norm_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sel_q <= sel_d;
      freq_q <= freq_d;
      duty_q <= duty_d;
      code_q <= code_d;
      dec_q <= dec_d;
      run_q <= run_d;
      acc_q <= acc_d;
      idle_q <= idle_d;
      err_q <= err_d;
      norm_q <= norm_d;
      act_q <= act_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ramp tick restarts when idle so the first step is a full 10 ms
  rpc_tick #(
    .TICKS(TICKS)
  ) u_tick (
    .clk(clk),
    .reset_n(reset_n),
    .restart(state_q == ST_IDLE),
    .tick(tick)
  );

  assign wave_run = (state_q != ST_IDLE) && !err_q;

  rpc_wave u_wave (
    .clk(clk),
    .reset_n(reset_n),
    .run(wave_run),
    .freq(freq_q),
    .duty(duty_q),
    .wave(pwm_out)
  );

  assign decel_flag = dec_q;
  assign run_flag = run_q;
  assign ramp_up_flag = acc_q;
  assign idle_flag = idle_q;
  assign error_flag = err_q;
  assign normal_flag = norm_q;
  assign active_flag = act_q;
  assign sel_state = sel_q;
  assign freq_actual = freq_q;
  assign duty_actual = duty_q;
  assign fault_code = code_q;

  ////////////////////////////////////////////////////////////////////////
  decel_phase_a: assert property (@(posedge clk) disable iff (!reset_n)
    decel_flag == (state_q == ST_DECEL))
    else $error("decel flag disagrees with state");

  run_phase_a: assert property (@(posedge clk) disable iff (!reset_n)
    run_flag |-> (state_q == ST_RUN) && !decel_flag && !ramp_up_flag)
    else $error("run flag outside run phase");

  accel_phase_a: assert property (@(posedge clk) disable iff (!reset_n)
    ramp_up_flag == (state_q == ST_ACCEL))
    else $error("ramp-up flag disagrees with state");

  sel_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
    (state_q != ST_IDLE) |=> $stable(sel_q))
    else $error("ramp target changed while running");

  idle_excl_a: assert property (@(posedge clk) disable iff (!reset_n)
    idle_flag == !(run_flag || ramp_up_flag || decel_flag))
    else $error("idle flag inconsistent with phase flags");

  hard_low_a: assert property (@(posedge clk) disable iff (!reset_n)
    hard_stop_cmd |-> ##2 !pwm_out)
    else $error("output not low after hard stop");

  hard_code_a: assert property (@(posedge clk) disable iff (!reset_n)
    hard_stop_cmd && (out_select == OUT_SEL_A) |=> error_flag && fault_code == ERR_HARD)
    else $error("hard stop code not reported");

  freq_code_a: assert property (@(posedge clk) disable iff (!reset_n)
    !hard_stop_cmd && (out_select == OUT_SEL_B) &&
    ($signed(freq_setpoint) > FREQ_MAX) |=> fault_code == ERR_FREQ)
    else $error("frequency fault code missing");

  normal_ok_a: assert property (@(posedge clk) disable iff (!reset_n)
    normal_flag |-> !error_flag && !idle_flag)
    else $error("normal flag with error or idle");

  active_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    !enable_in |=> !active_flag)
    else $error("active flag stayed after enable dropped");

endmodule
`default_nettype wire

// file: sim/rpc_load.sv
// field load model: counts clock cycles with the modulated pin high
// assumes the bench clears the count before each measured window
`default_nettype none
module rpc_load (
  // clock
  input wire logic clk,
  // pin and control
  input wire logic pwm_in,
  input wire logic clr,
  output int high_cnt
);
  timeunit 1ns;
  timeprecision 100ps;
  // only a clean high counts, so an unknown pin shows up as a short count
  always @(posedge clk) begin
    if (clr) begin
      high_cnt <= 0;
    end else if (pwm_in === 1'b1) begin
      high_cnt <= high_cnt + 1;
    end
  end
endmodule
`default_nettype wire

// file: sim/rpc_channel_bench.sv
// self-checking bench for one ramped pulse width channel
// assumes rpc_pkg, the design and rpc_load are compiled first; ramp tick shortened
`default_nettype none
module rpc_channel_bench
  import rpc_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TK = 20;
  localparam logic [15:0] OS_TAB [5] = '{16'h0002, 16'h0003, 16'h0004, 16'h0001, 16'h0005};
  localparam logic [15:0] DUTY_TAB [4] = '{16'h0000, 16'h02EE, 16'h00FA, 16'h03E8};
  logic clk, reset_n, enable_in, hard_stop_cmd, ramp_target_sel, clr;
  logic decel_flag, run_flag, ramp_up_flag, idle_flag, error_flag, normal_flag;
  logic active_flag, sel_state, pwm_out;
  logic [15:0] out_select, duty_setpoint, ramp_delay, duty_actual, fault_code;
  logic [31:0] freq_setpoint, freq_actual;
  int high_cnt, err_total, checks;
  wire logic [6:0] fl = {idle_flag, ramp_up_flag, run_flag, decel_flag, error_flag,
    normal_flag, active_flag};
  rpc_channel #(.TICKS(TK)) i_rpc_channel (.clk(clk), .reset_n(reset_n),
    .enable_in(enable_in), .out_select(out_select), .hard_stop_cmd(hard_stop_cmd),
    .ramp_target_sel(ramp_target_sel), .freq_setpoint(freq_setpoint),
    .duty_setpoint(duty_setpoint), .ramp_delay(ramp_delay), .decel_flag(decel_flag),
    .run_flag(run_flag), .ramp_up_flag(ramp_up_flag), .idle_flag(idle_flag),
    .error_flag(error_flag), .normal_flag(normal_flag), .active_flag(active_flag),
    .sel_state(sel_state), .freq_actual(freq_actual), .duty_actual(duty_actual),
    .fault_code(fault_code), .pwm_out(pwm_out));
  rpc_load i_rpc_load (.clk(clk), .pwm_in(pwm_out), .clr(clr), .high_cnt(high_cnt));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // all inputs change together on one rising edge
  task automatic drv(input logic en, input logic hs, input logic ts, input logic [15:0] os,
    input logic [31:0] f, input logic [15:0] d, input logic [15:0] rd);
    @(posedge clk);
    enable_in <= en;
    hard_stop_cmd <= hs;
    ramp_target_sel <= ts;
    out_select <= os;
    freq_setpoint <= f;
    duty_setpoint <= d;
    ramp_delay <= rd;
  endtask
  // bounded wait for the ramped value to take its next step
  task automatic wait_chg(input logic use_duty, output logic [31:0] val);
    logic [31:0] old;
    int n;
    old = use_duty ? 32'(duty_actual) : freq_actual;
    val = old;
    for (n = 0; n < 3 * TK && val === old; n++) begin
      @(posedge clk);
      #1;
      val = use_duty ? 32'(duty_actual) : freq_actual;
    end
    if (val === old) begin
      err_total++;
      $display("wait for ramp step ran out at %0t", $time);
      print_verdict();
    end
  endtask
  function automatic logic [15:0] exp_fault(logic hs, logic [15:0] os, logic [31:0] f,
    logic [15:0] d);
    if (os < 16'h0002 || os > 16'h0004) return 16'hFFFF;
    if (hs) return 16'h0001;
    if ($signed(f) < 0 || $signed(f) > 40000) return 16'h0003;
    if ($signed(d) < 0 || $signed(d) > 1000) return 16'h0005;
    return 16'h0000;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int i, k, e;
    logic [15:0] os, d, ef;
    logic [31:0] f, v, ev;
    logic hs;
    err_total = 0;
    checks = 0;
    clr = 1'b1;
    reset_n = 1'b0;
    enable_in = 1'b0;
    hard_stop_cmd = 1'b0;
    ramp_target_sel = 1'b0;
    out_select = 16'h0002;
    freq_setpoint = 32'h0;
    duty_setpoint = 16'h0;
    ramp_delay = 16'h0;
    void'($urandom(58593));
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    chk(fl, 7'h40);
    chk(fault_code, 16'h0000);
    chk(pwm_out, 1'b0);
    $display("test reset done");
    // corner cases first, then random words, invalid ones among them
    for (i = 0; i < 24; i++) begin
      os = OS_TAB[i < 5 ? i : (i < 12 ? int'(i == 6) : $urandom_range(4))];
      hs = (i == 5) || (i > 11 && $urandom_range(5) == 0);
      f = i == 6 ? 32'd40001 : i == 7 ? 32'hFFFF_FFFF : i == 8 ? 32'd40000 :
        32'($urandom_range(44000));
      d = i == 9 ? 16'd1001 : i == 10 ? 16'hFFFF : i == 11 ? 16'd1000 :
        16'($urandom_range(1100));
      drv(1'b1, hs, 1'b0, os, f, d, i == 8 ? 16'hFFFF : 16'h0000);
      cyc(4);
      ef = exp_fault(hs, os, f, d);
      chk(fault_code, ef);
      chk(error_flag, ef != 16'h0000);
      if (ef == 16'h0000) begin
        chk(fl, 7'h13);
        chk(freq_actual, f);
        chk(duty_actual, d);
      end else begin
        chk(fl, 7'h44);
        chk(pwm_out, 1'b0);
      end
    end
    $display("test faults done");
    // two whole periods at 40000 Hz are 5000 cycles
    for (k = 0; k < 4; k++) begin
      d = DUTY_TAB[k];
      drv(1'b1, 1'b0, 1'b0, 16'h0002, 32'd40000, d, 16'h0000);
      cyc(3);
      @(posedge clk);
      clr <= 1'b0;
      repeat (5000) @(posedge clk);
      clr <= 1'b1;
      #1;
      e = 5 * int'(d);
      chk(32'(high_cnt - e < 20 && e - high_cnt < 20), 32'h1);
    end
    $display("test duty done");
    drv(1'b0, 1'b0, 1'b1, 16'h0002, 32'd40000, 16'd500, 16'd4);
    cyc(5 * TK);
    chk(fl, 7'h40);
    drv(1'b1, 1'b0, 1'b1, 16'h0002, 32'd40000, 16'd500, 16'd4);
    cyc(2);
    chk(fl, 7'h23);
    chk(sel_state, 1'b1);
    chk(freq_actual, 32'h0);
    drv(1'b1, 1'b0, 1'b0, 16'h0002, 32'd40000, 16'd500, 16'd4);
    wait_chg(1'b0, v);
    chk(v, 32'd10000);
    drv(1'b1, 1'b0, 1'b0, 16'h0002, 32'd40000, 16'd500, 16'd8);
    ev = 32'd10000;
    for (k = 0; k < 6; k++) begin
      wait_chg(1'b0, v);
      ev = ev + 32'd5000;
      chk(v, ev);
    end
    chk(fl, 7'h13);
    chk(sel_state, 1'b1);
    drv(1'b0, 1'b0, 1'b0, 16'h0002, 32'd40000, 16'd500, 16'd8);
    cyc(2);
    chk(fl, 7'h0A);
    for (k = 0; k < 8; k++) begin
      wait_chg(1'b0, v);
      ev = ev - 32'd5000;
      chk(v, ev);
    end
    cyc(2);
    chk(fl, 7'h40);
    $display("test freq ramp done");
    drv(1'b1, 1'b0, 1'b0, 16'h0002, 32'd40000, 16'd1000, 16'd2);
    cyc(2);
    chk(fl, 7'h23);
    chk(sel_state, 1'b0);
    wait_chg(1'b1, v);
    chk(v, 32'd500);
    chk(freq_actual, 32'd40000);
    wait_chg(1'b1, v);
    chk(v, 32'd1000);
    chk(fl, 7'h13);
    $display("test duty ramp done");
    print_verdict();
  end
endmodule
`default_nettype wire
